// ### dv/rcs_sequencer_chk.sv
// Port-level assertions for the ripple calibration sequencer
`timescale 1ns/1ps
module rcs_sequencer_chk #(
  parameter int TICK_CYCLES = 4,
  parameter int FULL_TICKS = 27,
  parameter int QUICK_TICKS = 18,
  parameter int N_AMPS = 9
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Calibration
  input wire rcs_pkg::rcs_sw_type SWITCH_DRIVE,
  input wire logic CAL_ACTIVE,
  input wire logic CAL_FULL_TYPE,
  input wire logic CAL_ALL_AMPS,
  input wire logic [3:0] CAL_AMP_IDX,
  input wire logic CAL_BUSY_O
);
  // Tick phase at start is free, so allow one tick of slack
  localparam int FULL_LO = (FULL_TICKS - 1) * TICK_CYCLES;
  localparam int FULL_HI = FULL_TICKS * TICK_CYCLES + 2;
  localparam int QUICK_LO = (QUICK_TICKS - 1) * TICK_CYCLES;
  localparam int QUICK_HI = QUICK_TICKS * TICK_CYCLES + 2;
  logic rst_q_ff;
  logic [15:0] cnt_ff;
  rcs_pkg::rcs_sw_type sv_ff;
  always_ff @(posedge CLK) begin
    rst_q_ff <= SYS_RST;
    if (SYS_RST) begin
      cnt_ff <= '0;
      sv_ff <= rcs_pkg::SW_RESET;
    end else begin
      cnt_ff <= CAL_ACTIVE ? cnt_ff + 16'h1 : 16'h0;
      sv_ff <= CAL_ACTIVE ? sv_ff : SWITCH_DRIVE;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  sequence s_release;
    rst_q_ff && !SYS_RST;
  endsequence
  sequence s_full_run;
    CAL_ACTIVE && CAL_FULL_TYPE;
  endsequence
  a_auto_full: assert property (s_release |-> ##[1:3] s_full_run)
    else $error("no full calibration after reset");
  a_sw_forced: assert property (CAL_ACTIVE |-> SWITCH_DRIVE == rcs_pkg::SW_CAL)
    else $error("switches not in calibration setting");
  a_sw_restore: assert property ($fell(CAL_ACTIVE) |-> SWITCH_DRIVE == sv_ff)
    else $error("switches not restored");
  a_cal_length: assert property ($fell(CAL_ACTIVE) |-> (CAL_FULL_TYPE ?
    (int'(cnt_ff) >= FULL_LO && int'(cnt_ff) <= FULL_HI) :
    (int'(cnt_ff) >= QUICK_LO && int'(cnt_ff) <= QUICK_HI)))
    else $error("calibration length wrong");
  a_quick_phase: assert property (CAL_ALL_AMPS |-> CAL_ACTIVE && !CAL_FULL_TYPE)
    else $error("all-amplifier phase outside quick run");
  a_amp_step: assert property (s_full_run and $past(CAL_ACTIVE) |->
    CAL_AMP_IDX < N_AMPS && (CAL_AMP_IDX - $past(CAL_AMP_IDX)) <= 4'h1)
    else $error("amplifier index not sequential");
  a_busy_gated: assert property (CAL_BUSY_O |-> CAL_ACTIVE)
    else $error("busy pin active while idle");
  a_ready_zero: assert property (PSEL && PENABLE |-> PREADY)
    else $error("bus answer late");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("bus error outside access");
endmodule
bind rcs_sequencer rcs_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES), .FULL_TICKS(FULL_TICKS),
  .QUICK_TICKS(QUICK_TICKS), .N_AMPS(N_AMPS)) u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SWITCH_DRIVE(SWITCH_DRIVE), .CAL_ACTIVE(CAL_ACTIVE), .CAL_FULL_TYPE(CAL_FULL_TYPE),
  .CAL_ALL_AMPS(CAL_ALL_AMPS), .CAL_AMP_IDX(CAL_AMP_IDX), .CAL_BUSY_O(CAL_BUSY_O));

// ### dv/rcs_sequencer_tb.sv
// Self-checking bench for the ripple calibration sequencer
`timescale 1ns/1ps
module rcs_sequencer_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = '0;
  logic [31:0] pwd = '0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic rdy, serr, err, ca, cf, bo, boe, slow, irq;
  logic [3:0] mon = '0;
  logic [1:0] scl;
  rcs_pkg::rcs_sw_type sw;
  int n_errors = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  rcs_sequencer #(.TICK_CYCLES(4), .FULL_TICKS(27), .QUICK_TICKS(18), .N_AMPS(9),
    .SCHED_BASE(5)) dut_u (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr),
    .HV_POS_RAIL_LOW(mon[0]), .HV_NEG_RAIL_LOW(mon[1]), .OUT_SAT_HIGH(mon[2]),
    .OUT_SAT_LOW(mon[3]), .SWITCH_DRIVE(sw), .CAL_ACTIVE(ca), .CAL_FULL_TYPE(cf),
    .CAL_ALL_AMPS(), .CAL_AMP_IDX(), .CP_CLK_SLOW(slow), .OUT_SCALE_SEL(scl),
    .CAL_BUSY_O(bo), .CAL_BUSY_OE(boe), .IRQ(irq));
  task automatic final_report;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    rd = prd;
    err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    chk(32'(rdy), 32'h1);
    // Let the write settle before callers look at outputs
    #1;
  endtask
  // Bounded wait for the calibration flag to reach a level
  task automatic wait_ca(input logic v, input int lim);
    int n;
    n = 0;
    while (ca !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(ca), 32'(v));
  endtask
  task automatic t_power;
    wait_ca(1'b1, 4);
    chk(32'(cf), 32'h1);
    chk(32'(slow), 32'h0);
    wait_ca(1'b0, 200);
  endtask
  task automatic t_quiet;
    logic seen;
    seen = 1'b0;
    repeat (300) begin
      @(posedge clk);
      seen = seen | ca;
    end
    chk(32'(seen), 32'h0);
  endtask
  task automatic t_trig;
    apb(1'b1, rcs_pkg::OFS_SWITCH, 32'h0000000F);
    apb(1'b1, rcs_pkg::OFS_CTRL, 32'h00000181);
    apb(1'b1, rcs_pkg::OFS_TRIG, 32'h00000001);
    wait_ca(1'b1, 6);
    chk(32'(cf), 32'h0);
    chk(32'(sw), 32'(rcs_pkg::SW_CAL));
    chk(32'(bo), 32'h1);
    apb(1'b1, rcs_pkg::OFS_SWITCH, 32'h00000003);
    // host asks for a further calibration mid-run
    apb(1'b1, rcs_pkg::OFS_TRIG, 32'h00000001);
    apb(1'b0, rcs_pkg::OFS_TRIG, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wait_ca(1'b0, 200);
    chk(32'(sw), 32'h0000000F);
    wait_ca(1'b1, 6);
    wait_ca(1'b0, 200);
    apb(1'b0, rcs_pkg::OFS_TRIG, 32'h0);
    chk(rd & 32'h1, 32'h0);
  endtask
  task automatic t_sched;
    apb(1'b1, rcs_pkg::OFS_CTRL, 32'h00000002);
    wait_ca(1'b1, 60);
    chk(32'(cf), 32'h1);
    wait_ca(1'b0, 200);
    wait_ca(1'b1, 6);
    apb(1'b1, rcs_pkg::OFS_CTRL, 32'h0);
    repeat (150) @(posedge clk);
    wait_ca(1'b0, 200);
  endtask
  task automatic t_rails;
    apb(1'b1, rcs_pkg::OFS_IRQ_MASK, 32'h00000006);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      mon <= 4'h1 << i;
      repeat (6) @(posedge clk);
      mon <= 4'h0;
      apb(1'b0, rcs_pkg::OFS_IRQ_STAT, 32'h0);
      chk(rd & 32'h6, (i < 2) ? 32'h2 : 32'h4);
      chk(32'(irq), 32'h1);
      apb(1'b1, rcs_pkg::OFS_IRQ_STAT, 32'h00000007);
      chk(32'(irq), 32'h0);
      if (i < 2) begin
        wait_ca(1'b1, 10);
        chk(32'(cf), 32'h1);
        wait_ca(1'b0, 200);
      end
    end
  endtask
  task automatic t_cfg;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, rcs_pkg::OFS_CTRL, 32'h00000190 | (32'(s) << 5));
      chk(32'(scl), (s == 3) ? 32'h0 : 32'(s));
      chk(32'(slow), 32'h1);
      chk(32'(boe), 32'h1);
    end
    // Soft reset restores control and switch defaults and forces a full run
    apb(1'b1, rcs_pkg::OFS_TRIG, 32'h00000002);
    wait_ca(1'b1, 6);
    chk(32'(cf), 32'h1);
    apb(1'b0, rcs_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    wait_ca(1'b0, 200);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_power;
    t_quiet;
    t_trig;
    t_sched;
    t_rails;
    t_cfg;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report;
  end
endmodule

// ### verilog/rcs_pkg.sv
// Shared constants, register map and types of the ripple calibration sequencer
package rcs_pkg;

  // Clock and time base
  localparam int CLK_KHZ = 40000;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = (TICK_US * CLK_KHZ) / 1000;

  // Calibration durations
  localparam int FULL_CAL_MS = 85;
  localparam int QUICK_CAL_MS = 8;
  localparam int FULL_CAL_TICKS = (FULL_CAL_MS * 1000) / TICK_US;
  localparam int QUICK_CAL_TICKS = (QUICK_CAL_MS * 1000) / TICK_US;
  localparam int N_AMPS = 9;

  // Schedule base interval in ticks, doubled per code step
  localparam int SCHED_BASE_TICKS = 10000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG = 8'h04;
  localparam logic [7:0] OFS_SWITCH = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // Trigger register bit positions
  localparam int CAL_TRIGGER_BIT = 0;
  localparam int TRIG_SOFT_RST_BIT = 1;

  // Event bit positions in status and mask
  localparam int EV_CAL_DONE = 0;
  localparam int EV_HV_BROWNOUT = 1;
  localparam int EV_OUT_ERR = 2;
  localparam int N_EVENTS = 3;

  // Output gain codes
  localparam logic [1:0] SCALE_UNITY = 2'h0;
  localparam logic [1:0] SCALE_1P25 = 2'h1;
  localparam logic [1:0] SCALE_1P375 = 2'h2;

  typedef struct packed {
    logic busy_dir;
    logic busy_en;
    logic [1:0] out_scale;
    logic cp_clk_slow;
    logic [2:0] sched_en;
    logic cal_sel;
  } rcs_ctrl_type;

  localparam rcs_ctrl_type CTRL_RESET = '{busy_dir: 1'b0, busy_en: 1'b0,
                                           out_scale: SCALE_UNITY, cp_clk_slow: 1'b0,
                                           sched_en: 3'h0, cal_sel: 1'b0};

  typedef struct packed {
    logic test_neg_switch;
    logic test_pos_switch;
    logic input_b_neg_switch;
    logic input_b_pos_switch;
    logic input_a_neg_switch;
    logic input_a_pos_switch;
  } rcs_sw_type;

  localparam rcs_sw_type SW_RESET = '{default: 1'b0};
  localparam rcs_sw_type SW_CAL = '{test_neg_switch: 1'b1, test_pos_switch: 1'b1,
                                     default: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FULL = 2'b01,
    ST_QUICK_ALL = 2'b10,
    ST_QUICK_ADJ = 2'b11
  } rcs_state_type;

endpackage

// ### verilog/rcs_sequencer.sv
// Ripple calibration sequencer with APB registers, supply and output monitors
// Function
// - Auto calibration at power-on, brown-out, soft reset
// - During calibration open inputs, close test switches
// - Restore input switches after calibration ends
// - Select bit picks full or quick type
// - Full: amplifiers in turn, about 85 ms
// - Automatic calibrations are always full type
// - Quick: all at once, then adjust, 8 ms
// - No extra calibrations without schedule or trigger
// - Schedule field repeats calibrations at set interval
// - Trigger bit write starts selected calibration type
// - Brown-out flag when a high rail sags
// - Output error flag on output saturation
// - Charge pump clock 16 MHz, optionally 8
// - Two bits select one of three gains
// - Busy pin active while calibration runs
`timescale 1ns/1ps
module rcs_sequencer #(
  parameter int TICK_CYCLES = rcs_pkg::TICK_CYCLES,
  parameter int FULL_TICKS = rcs_pkg::FULL_CAL_TICKS,
  parameter int QUICK_TICKS = rcs_pkg::QUICK_CAL_TICKS,
  parameter int N_AMPS = rcs_pkg::N_AMPS,
  parameter int SCHED_BASE = rcs_pkg::SCHED_BASE_TICKS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Supply and output comparators
  input wire logic HV_POS_RAIL_LOW,
  input wire logic HV_NEG_RAIL_LOW,
  input wire logic OUT_SAT_HIGH,
  input wire logic OUT_SAT_LOW,
  // Switch drive
  output rcs_pkg::rcs_sw_type SWITCH_DRIVE,
  // Calibration engine control
  output logic CAL_ACTIVE,
  output logic CAL_FULL_TYPE,
  output logic CAL_ALL_AMPS,
  output logic [3:0] CAL_AMP_IDX,
  // Analog configuration
  output logic CP_CLK_SLOW,
  output logic [1:0] OUT_SCALE_SEL,
  // Busy pin
  output logic CAL_BUSY_O,
  output logic CAL_BUSY_OE,
  // Interrupt
  output logic IRQ
);

  localparam int NE = rcs_pkg::N_EVENTS;
  localparam logic [9:0] FULL_LAST = 10'(FULL_TICKS - 1);
  localparam logic [9:0] FULL_SLOT = 10'(FULL_TICKS / N_AMPS);
  localparam logic [9:0] QALL_LAST = 10'(QUICK_TICKS / 2 - 1);
  localparam logic [9:0] QUICK_LAST = 10'(QUICK_TICKS - 1);
  localparam logic [9:0] QUICK_SLOT = 10'((QUICK_TICKS - QUICK_TICKS / 2) / N_AMPS);
  localparam logic [3:0] AMP_LAST = 4'(N_AMPS - 1);
  localparam logic [23:0] SCHED_UNIT = 24'(SCHED_BASE);

  typedef struct packed {
    rcs_pkg::rcs_state_type st;
    logic [9:0] cnt_tot;
    logic [9:0] cnt_slot;
    logic [3:0] amp;
    logic cur_full;
    rcs_pkg::rcs_ctrl_type ctrl;
    rcs_pkg::rcs_sw_type sw;
    logic pend_full;
    logic pend_trig;
    logic pend_sched;
    logic [23:0] sched_cnt;
    logic [NE-1:0] stat;
    logic [NE-1:0] mask;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic bo_prev;
    logic [31:0] prdata;
    logic pslverr;
  } rcs_top_type;

  rcs_top_type s_ff;
  rcs_top_type nxt_s;
  logic tick;

  // 100 us time base for all calibration and schedule timing
  rcs_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk(CLK),
    .rst(SYS_RST),
    .tick(tick)
  );

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == rcs_pkg::OFS_CTRL) || (a == rcs_pkg::OFS_TRIG) ||
              (a == rcs_pkg::OFS_SWITCH) || (a == rcs_pkg::OFS_STATUS) ||
              (a == rcs_pkg::OFS_IRQ_STAT) || (a == rcs_pkg::OFS_IRQ_MASK);
  endfunction

  logic busy;
  logic wr;
  logic brownout;
  logic saturated;
  logic [NE-1:0] ev;
  logic [NE-1:0] w1c;
  logic [23:0] interval;
  logic [2:0] sched_code;
  logic start_full;

  always_comb begin
    nxt_s = s_ff;
    busy = (s_ff.st != rcs_pkg::ST_IDLE);
    wr = PSEL && PENABLE && PWRITE && addr_ok(PADDR);
    ev = '0;
    w1c = '0;
    start_full = 1'b0;
    sched_code = s_ff.ctrl.sched_en;
    interval = SCHED_UNIT << (sched_code - 3'h1);

    // Comparator pins cross in through two flops
    nxt_s.sync1 = {HV_POS_RAIL_LOW, HV_NEG_RAIL_LOW, OUT_SAT_HIGH, OUT_SAT_LOW};
    nxt_s.sync2 = s_ff.sync1;
    brownout = s_ff.sync2[3] | s_ff.sync2[2];
    saturated = s_ff.sync2[1] | s_ff.sync2[0];
    nxt_s.bo_prev = brownout;
    ev[rcs_pkg::EV_HV_BROWNOUT] = brownout;
    ev[rcs_pkg::EV_OUT_ERR] = saturated;
    if (brownout && !s_ff.bo_prev) begin
      nxt_s.pend_full = 1'b1;
    end

    // periodic request; code zero never fires
    if (sched_code == 3'h0) begin
      nxt_s.sched_cnt = '0;
    end else if (tick) begin
      if (s_ff.sched_cnt >= interval - 24'h000001) begin
        nxt_s.sched_cnt = '0;
        nxt_s.pend_sched = 1'b1;
      end else begin
        nxt_s.sched_cnt = s_ff.sched_cnt + 24'h000001;
      end
    end

    unique case (s_ff.st)
      rcs_pkg::ST_IDLE: begin
        // queued requests served only from idle
        if (s_ff.pend_full || s_ff.pend_trig || s_ff.pend_sched) begin
          // automatic requests force full; type select
          start_full = s_ff.pend_full || !s_ff.ctrl.cal_sel;
          nxt_s.cur_full = start_full;
          if (s_ff.pend_full) begin
            nxt_s.pend_full = 1'b0;
          end else begin
            nxt_s.pend_trig = 1'b0;
            nxt_s.pend_sched = 1'b0;
          end
          nxt_s.cnt_tot = '0;
          nxt_s.cnt_slot = '0;
          nxt_s.amp = '0;
          nxt_s.st = start_full ? rcs_pkg::ST_FULL : rcs_pkg::ST_QUICK_ALL;
        end
      end
      rcs_pkg::ST_FULL: begin
        if (tick) begin
          nxt_s.cnt_tot = s_ff.cnt_tot + 10'h001;
          nxt_s.cnt_slot = s_ff.cnt_slot + 10'h001;
          if (s_ff.cnt_slot == FULL_SLOT - 10'h001 && s_ff.amp != AMP_LAST) begin
            nxt_s.amp = s_ff.amp + 4'h1;
            nxt_s.cnt_slot = '0;
          end
          if (s_ff.cnt_tot == FULL_LAST) begin
            nxt_s.st = rcs_pkg::ST_IDLE;
            ev[rcs_pkg::EV_CAL_DONE] = 1'b1;
          end
        end
      end
      rcs_pkg::ST_QUICK_ALL: begin
        // shared code for all amplifiers first
        if (tick) begin
          nxt_s.cnt_tot = s_ff.cnt_tot + 10'h001;
          if (s_ff.cnt_tot == QALL_LAST) begin
            nxt_s.st = rcs_pkg::ST_QUICK_ADJ;
            nxt_s.cnt_slot = '0;
            nxt_s.amp = '0;
          end
        end
      end
      rcs_pkg::ST_QUICK_ADJ: begin
        if (tick) begin
          nxt_s.cnt_tot = s_ff.cnt_tot + 10'h001;
          nxt_s.cnt_slot = s_ff.cnt_slot + 10'h001;
          if (s_ff.cnt_slot == QUICK_SLOT - 10'h001 && s_ff.amp != AMP_LAST) begin
            nxt_s.amp = s_ff.amp + 4'h1;
            nxt_s.cnt_slot = '0;
          end
          if (s_ff.cnt_tot == QUICK_LAST) begin
            nxt_s.st = rcs_pkg::ST_IDLE;
            ev[rcs_pkg::EV_CAL_DONE] = 1'b1;
          end
        end
      end
    endcase

    // Register writes in the access phase
    if (wr) begin
      unique case (PADDR)
        rcs_pkg::OFS_CTRL: begin
          nxt_s.ctrl = rcs_pkg::rcs_ctrl_type'(PWDATA[8:0]);
          if (PWDATA[6:5] == 2'h3) begin
            nxt_s.ctrl.out_scale = rcs_pkg::SCALE_UNITY;
          end
        end
        rcs_pkg::OFS_TRIG: begin
          // software request; no restart of a running one
          if (PWDATA[rcs_pkg::CAL_TRIGGER_BIT]) begin
            nxt_s.pend_trig = 1'b1;
          end
        end
        rcs_pkg::OFS_SWITCH: begin
          // Held off while calibrating so restore is exact
          if (!busy) begin
            nxt_s.sw = rcs_pkg::rcs_sw_type'(PWDATA[5:0]);
          end
        end
        rcs_pkg::OFS_IRQ_STAT: begin
          w1c = PWDATA[NE-1:0];
        end
        rcs_pkg::OFS_IRQ_MASK: begin
          nxt_s.mask = PWDATA[NE-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set beats clear in the same cycle
    nxt_s.stat = (s_ff.stat & ~w1c) | ev;

    // soft reset restores control and switch defaults and queues full calibration
    if (wr && PADDR == rcs_pkg::OFS_TRIG && PWDATA[rcs_pkg::TRIG_SOFT_RST_BIT]) begin
      nxt_s.st = rcs_pkg::ST_IDLE;
      nxt_s.ctrl = rcs_pkg::CTRL_RESET;
      nxt_s.sw = rcs_pkg::SW_RESET;
      nxt_s.pend_full = 1'b1;
      nxt_s.pend_trig = 1'b0;
      nxt_s.pend_sched = 1'b0;
      nxt_s.sched_cnt = '0;
      nxt_s.cnt_tot = '0;
      nxt_s.cnt_slot = '0;
      nxt_s.amp = '0;
    end

    // Read data captured in the setup phase, answered with no wait
    if (PSEL && !PENABLE) begin
      nxt_s.pslverr = !addr_ok(PADDR);
      unique case (PADDR)
        rcs_pkg::OFS_CTRL: nxt_s.prdata = {23'h000000, s_ff.ctrl};
        rcs_pkg::OFS_TRIG: nxt_s.prdata = {31'h00000000, s_ff.pend_trig};
        rcs_pkg::OFS_SWITCH: nxt_s.prdata = {26'h0000000, s_ff.sw};
        rcs_pkg::OFS_STATUS: nxt_s.prdata = {20'h00000, s_ff.amp, 2'h0, s_ff.st,
                                             s_ff.pend_sched, s_ff.pend_full,
                                             s_ff.cur_full, busy};
        rcs_pkg::OFS_IRQ_STAT: nxt_s.prdata = {29'h00000000, s_ff.stat};
        rcs_pkg::OFS_IRQ_MASK: nxt_s.prdata = {29'h00000000, s_ff.mask};
        default: nxt_s.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_ff <= '0;
      s_ff.ctrl <= rcs_pkg::CTRL_RESET;
      s_ff.sw <= rcs_pkg::SW_RESET;
      // power-on calibration queued out of reset
      s_ff.pend_full <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign PREADY = PSEL && PENABLE;
  assign PRDATA = s_ff.prdata;
  assign PSLVERR = PSEL && PENABLE && s_ff.pslverr;

  // calibration override; stored settings return after
  assign SWITCH_DRIVE = (s_ff.st != rcs_pkg::ST_IDLE) ? rcs_pkg::SW_CAL : s_ff.sw;

  assign CAL_ACTIVE = (s_ff.st != rcs_pkg::ST_IDLE);
  assign CAL_FULL_TYPE = s_ff.cur_full;
  assign CAL_ALL_AMPS = (s_ff.st == rcs_pkg::ST_QUICK_ALL);
  assign CAL_AMP_IDX = s_ff.amp;

  assign CP_CLK_SLOW = s_ff.ctrl.cp_clk_slow;
  assign OUT_SCALE_SEL = s_ff.ctrl.out_scale;

  // busy pin follows the running calibration
  assign CAL_BUSY_O = s_ff.ctrl.busy_en && (s_ff.st != rcs_pkg::ST_IDLE);
  assign CAL_BUSY_OE = s_ff.ctrl.busy_dir;

  assign IRQ = |(s_ff.stat & s_ff.mask);

endmodule

// ### verilog/rcs_tick_div.sv
// Divider that issues a one-cycle enable pulse every DIV clock cycles
`timescale 1ns/1ps
module rcs_tick_div #(
  parameter int DIV = 4000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Enable pulse
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } rcs_div_type;

  localparam logic [15:0] LAST = 16'(DIV - 1);

  rcs_div_type s_ff;
  rcs_div_type nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt == LAST) begin
      nxt_s.cnt = 16'h0000;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

endmodule
